// ===== hw/spi_cfg_pkg.sv
// constants and types shared by the serial configuration port
`default_nettype none
package spi_cfg_pkg;
	// ----------------------------------------------------------------
	// register map (address word bit 0 set means write)
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_LINE_LENGTH  = 16'h0200;
	localparam logic [15:0] ADDR_SENSOR_STATE = 16'h4018;
	localparam logic [15:0] ADDR_SOFT_RESET   = 16'h4060;
	localparam int          WR_FLAG_BIT       = 0;
	localparam int          SOFT_RESET_BIT    = 0;

	localparam logic [15:0] RST_LINE_LENGTH  = 16'h0560;
	localparam logic [15:0] RST_SENSOR_STATE = 16'h0000;

	// ----------------------------------------------------------------
	// transfer framing: 16 address bits then 16 data bits
	// ----------------------------------------------------------------
	localparam logic [5:0] ADDR_LAST_BIT = 6'h0f;
	localparam logic [5:0] DATA_FIRST    = 6'h10;
	localparam logic [5:0] DATA_LAST_BIT = 6'h1f;
	localparam logic [5:0] FRAME_BITS    = 6'h20;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          SYS_CLK_MHZ    = 200;
	localparam int          FETCH_MAX_NS   = 1500;
	localparam int          FETCH_MAX_INT  = FETCH_MAX_NS * SYS_CLK_MHZ / 1000;
	localparam logic [9:0]  FETCH_MAX_CYC  = FETCH_MAX_INT[9:0];
	localparam logic [9:0]  FETCH_FAST_CYC = 10'h001;

	// synchroniser reset pattern {mosi, csn, sck}: bus idle, clock high
	localparam logic [2:0]  SYNC_RST = 3'h3;

	typedef enum logic [1:0] {
		ST_STANDBY,
		ST_IDLE,
		ST_CONFIG,
		ST_STREAMING
	} sensor_state_e;
endpackage
`default_nettype wire

// ===== hw/spi_sync_if.sv
// synchronised serial pins passed from the synchroniser to the port core
`default_nettype none
interface spi_sync_if;
	logic sck;
	logic csn;
	logic mosi;
	modport src (output sck, csn, mosi);
	modport dst (input sck, csn, mosi);
endinterface
`default_nettype wire

// ===== hw/spi_pin_sync.sv
// two-stage synchroniser for the serial pins
`default_nettype none
module spi_pin_sync
	import spi_cfg_pkg::*;
(
	// clock and reset
	input  wire logic   sys_clk,
	input  wire logic   nrst,
	input  wire logic   ce,
	// raw pins
	input  wire logic   sck_pin,
	input  wire logic   csn_n_pin,
	input  wire logic   mosi_pin,
	// synchronised side
	spi_sync_if.src     sy
);
	typedef struct packed {
		logic [2:0] ff1;
		logic [2:0] ff2;
	} sync_s;

	sync_s s_q;
	sync_s s_d;

	always_comb begin
		s_d     = s_q;
		s_d.ff1 = {mosi_pin, csn_n_pin, sck_pin};
		s_d.ff2 = s_q.ff1;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '{ff1: SYNC_RST, ff2: SYNC_RST};
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// only the second stage leaves this module
	assign sy.sck  = s_q.ff2[0];
	assign sy.csn  = s_q.ff2[1];
	assign sy.mosi = s_q.ff2[2];
endmodule
`default_nettype wire

// ===== hw/sensor_spi_config_slave.sv
// serial configuration slave with shadow and active register stores
//
// Contract
// - sensor is slave; host starts every transfer
// - respond only while chip select is low
// - read data on miso, commands from mosi
// - clock idles high, sample on rising edge
// - read fetch takes at most 1.5 us
// - every write lands in the shadow store
// - shadow copied at frame start or state entry
// - reads return the shadow copy
// - restricted write visible, applied after config pass; the code applies it on config or idle entry
// - unrestricted registers writable in every state
// - standby accepts only state and soft-reset writes
`default_nettype none
module sensor_spi_config_slave
	import spi_cfg_pkg::*;
(
	// clock and reset
	input  wire logic           sys_clk,
	input  wire logic           nrst,
	input  wire logic           ce,
	// serial pins
	input  wire logic           sck,
	input  wire logic           csn_n,
	input  wire logic           mosi,
	output logic                miso,
	output logic                miso_oe_n,
	// sensor core side
	input  wire sensor_state_e  sensor_state,
	input  wire logic           frame_start,
	output logic [15:0]         line_length,
	output logic [15:0]         streaming_state_req,
	output logic                soft_reset
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic          sck_prev;
		logic [5:0]    cnt;
		logic [15:0]   shift;
		logic [15:0]   addr;
		logic          is_wr;
		logic [15:0]   rd_data;
		logic [9:0]    fetch_cnt;
		logic          fetch_busy;
		logic [15:0]   len_sh;
		logic [15:0]   len_act;
		logic [15:0]   st_sh;
		logic [15:0]   st_act;
		logic          sr_pend;
		logic          soft_reset;
		sensor_state_e prev_state;
		logic          miso;
		logic          miso_oe_n;
	} core_s;

	localparam core_s CORE_RST = '{
		sck_prev:   1'b1,
		cnt:        6'h00,
		shift:      16'h0000,
		addr:       16'h0000,
		is_wr:      1'b0,
		rd_data:    16'h0000,
		fetch_cnt:  10'h000,
		fetch_busy: 1'b0,
		len_sh:     RST_LINE_LENGTH,
		len_act:    RST_LINE_LENGTH,
		st_sh:      RST_SENSOR_STATE,
		st_act:     RST_SENSOR_STATE,
		sr_pend:    1'b0,
		soft_reset: 1'b0,
		prev_state: ST_STANDBY,
		miso:       1'b0,
		miso_oe_n:  1'b1
	};

	core_s s_q;
	core_s s_d;

	spi_sync_if sy ();

	spi_pin_sync u_sync (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.ce        (ce),
		.sck_pin   (sck),
		.csn_n_pin (csn_n),
		.mosi_pin  (mosi),
		.sy        (sy)
	);

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] reg_of(input logic [15:0] a);
		reg_of = {a[15:1], 1'b0};
	endfunction

	function automatic logic [9:0] fetch_lat(input logic [15:0] a);
		// line length sits in fast storage, the rest goes through the controller
		fetch_lat = (reg_of(a) == ADDR_LINE_LENGTH) ? FETCH_FAST_CYC : FETCH_MAX_CYC;
	endfunction

	logic        sel;
	logic        rise;
	logic        fall;
	logic        addr_done;
	logic        data_done;
	logic [15:0] word_in;
	logic        wr_ok;
	logic        len_apply;
	logic        any_apply;
	logic [15:0] shadow_rd;

	always_comb begin
		sel       = !sy.csn;
		rise      = sel && sy.sck && !s_q.sck_prev;
		fall      = sel && !sy.sck && s_q.sck_prev;
		word_in   = {s_q.shift[14:0], sy.mosi};
		addr_done = rise && (s_q.cnt == ADDR_LAST_BIT);
		data_done = rise && (s_q.cnt == DATA_LAST_BIT) && s_q.is_wr;
		// standby lets only the state and soft-reset registers through
		wr_ok     = (sensor_state != ST_STANDBY)
			|| (reg_of(s_q.addr) == ADDR_SENSOR_STATE)
			|| (reg_of(s_q.addr) == ADDR_SOFT_RESET);
		// restricted register takes effect only on entering config or idle
		len_apply = ((sensor_state == ST_CONFIG) && (s_q.prev_state != ST_CONFIG))
			|| ((sensor_state == ST_IDLE) && (s_q.prev_state != ST_IDLE));
		// unrestricted ones wait for a frame boundary only while streaming
		any_apply = frame_start || (sensor_state != ST_STREAMING);
		case (reg_of(s_q.addr))
			ADDR_LINE_LENGTH:  shadow_rd = s_q.len_sh;
			ADDR_SENSOR_STATE: shadow_rd = s_q.st_sh;
			ADDR_SOFT_RESET:   shadow_rd = {15'h0000, s_q.sr_pend};
			default:           shadow_rd = 16'h0000;
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d            = s_q;
		s_d.sck_prev   = sy.sck;
		s_d.prev_state = sensor_state;
		s_d.soft_reset = 1'b0;

		// register fetch after a read address
		if (s_q.fetch_busy) begin
			if (s_q.fetch_cnt == FETCH_FAST_CYC) begin
				s_d.fetch_busy = 1'b0;
				s_d.rd_data    = shadow_rd;
			end else begin
				s_d.fetch_cnt = s_q.fetch_cnt - 10'h001;
			end
		end

		// active store updates read the old shadow, so a same-cycle write waits
		if (len_apply) begin
			s_d.len_act = s_q.len_sh;
		end
		if (any_apply) begin
			s_d.st_act = s_q.st_sh;
			if (s_q.sr_pend) begin
				s_d.soft_reset = 1'b1;
				s_d.sr_pend    = 1'b0;
			end
		end

		// serial framing, slave only: nothing moves without host clock
		if (!sel) begin
			s_d.cnt       = 6'h00;
			s_d.miso_oe_n = 1'b1;
			s_d.miso      = 1'b0;
		end else begin
			s_d.miso_oe_n = 1'b0;
			if (rise && (s_q.cnt != FRAME_BITS)) begin
				s_d.shift = word_in;
				s_d.cnt   = s_q.cnt + 6'h01;
			end
			if (addr_done) begin
				s_d.addr    = word_in;
				s_d.is_wr   = word_in[WR_FLAG_BIT];
				s_d.rd_data = 16'h0000;
				if (!word_in[WR_FLAG_BIT]) begin
					s_d.fetch_busy = 1'b1;
					s_d.fetch_cnt  = fetch_lat(word_in);
				end
			end
			// mode 3: drive on the falling edge, host samples on the rising
			if (fall && (s_q.cnt >= DATA_FIRST) && (s_q.cnt <= DATA_LAST_BIT)
					&& !s_q.is_wr) begin
				s_d.miso = s_q.rd_data[~s_q.cnt[3:0]];
			end
		end

		// writes go to the shadow store only; a new write beats an apply
		if (data_done && wr_ok) begin
			case (reg_of(s_q.addr))
				ADDR_LINE_LENGTH:  s_d.len_sh = word_in;
				ADDR_SENSOR_STATE: s_d.st_sh = word_in;
				ADDR_SOFT_RESET: begin
					if (word_in[SOFT_RESET_BIT]) begin
						s_d.sr_pend = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= CORE_RST;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign miso                = s_q.miso;
	assign miso_oe_n           = s_q.miso_oe_n;
	assign line_length         = s_q.len_act;
	assign streaming_state_req = s_q.st_act;
	assign soft_reset          = s_q.soft_reset;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_deselect_quiet;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && !sel) |=> (miso_oe_n && (s_q.cnt == 6'h00));
	endproperty
	a_deselect_quiet: assert property (p_deselect_quiet) else $error("port active while deselected");

	property p_fetch_bound;
		@(posedge sys_clk) disable iff (!nrst || !ce)
		$rose(s_q.fetch_busy) |-> ##[1:300] !s_q.fetch_busy;
	endproperty
	a_fetch_bound: assert property (p_fetch_bound) else $error("read fetch exceeded limit");

	property p_shadow_only;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && data_done && wr_ok && (reg_of(s_q.addr) == ADDR_LINE_LENGTH) && !len_apply)
		|=> (s_q.len_sh == $past(word_in)) && $stable(s_q.len_act);
	endproperty
	a_shadow_only: assert property (p_shadow_only) else $error("write reached active store");

	property p_apply_entry;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && len_apply) |=> (s_q.len_act == $past(s_q.len_sh));
	endproperty
	a_apply_entry: assert property (p_apply_entry) else $error("shadow not applied on entry");

	property p_read_shadow;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && s_q.fetch_busy && (s_q.fetch_cnt == FETCH_FAST_CYC))
		|=> (s_q.rd_data == $past(shadow_rd)) && !s_q.fetch_busy;
	endproperty
	a_read_shadow: assert property (p_read_shadow) else $error("read data not from shadow");

	property p_standby_refuse;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && data_done && (sensor_state == ST_STANDBY)
			&& (reg_of(s_q.addr) == ADDR_LINE_LENGTH)) |=> $stable(s_q.len_sh);
	endproperty
	a_standby_refuse: assert property (p_standby_refuse) else $error("standby write accepted");

	property p_stream_accept;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && data_done && (sensor_state == ST_STREAMING)
			&& (reg_of(s_q.addr) == ADDR_SENSOR_STATE)) |=> (s_q.st_sh == $past(word_in));
	endproperty
	a_stream_accept: assert property (p_stream_accept) else $error("streaming write dropped");

	property p_miso_bit;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && fall && !s_q.is_wr && (s_q.cnt == DATA_FIRST))
		|=> (miso == $past(s_q.rd_data[15])) && !miso_oe_n;
	endproperty
	a_miso_bit: assert property (p_miso_bit) else $error("first read bit not msb");

	property p_bit_count;
		@(posedge sys_clk) disable iff (!nrst)
		(ce && rise && (s_q.cnt < FRAME_BITS)) |=> (s_q.cnt == $past(s_q.cnt) + 6'h01);
	endproperty
	a_bit_count: assert property (p_bit_count) else $error("bit counter slipped");
endmodule
`default_nettype wire

// ===== dv/spi_host_model.sv
// host side of the serial configuration link, acting as bus master
`default_nettype none
module spi_host_model
	import spi_cfg_pkg::*;
(
	// bench clock used to pace the link
	input  wire logic sys_clk,
	// serial pins
	output var  logic sck,
	output var  logic csn_n,
	output var  logic mosi,
	input  wire logic miso,
	input  wire logic miso_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------------------------------
	// link timing
	// ----------------------------------------------------------------
	// 8 bench cycles a half period gives an 80 ns link clock
	localparam int HALF       = 8;
	// 910 cycles is 4.55 us, just over three times the 1.5 us fetch limit that holds in every state; the host always waits that long on a read
	localparam int FETCH_WAIT = 910;

	initial begin
		sck = 1'b1;
		csn_n = 1'b1;
		mosi = 1'b0;
	end

	// ----------------------------------------------------------------
	// one frame; nbits below 32 aborts the frame early
	// ----------------------------------------------------------------
	task automatic xfer(input logic [15:0] addr, input logic [15:0] data, input int nbits,
		output logic [15:0] rdata);
		logic [31:0] word;
		word = {addr, data};
		rdata = 16'h0000;
		@(negedge sys_clk);
		csn_n = 1'b0;
		repeat (HALF) @(negedge sys_clk);
		for (int i = 0; i < nbits; i++) begin
			sck = 1'b0;
			mosi = word[31 - i];
			repeat (HALF) @(negedge sys_clk);
			sck = 1'b1;
			// an undriven line reads as unknown so it never matches
			if (i >= 16)
				rdata[31 - i] = miso_oe_n ? 1'bx : miso;
			repeat (HALF) @(negedge sys_clk);
			if (i == 15 && !addr[WR_FLAG_BIT])
				repeat (FETCH_WAIT) @(negedge sys_clk);
		end
		csn_n = 1'b1;
		mosi = ~mosi;
		repeat (HALF) @(negedge sys_clk);
	endtask
endmodule
`default_nettype wire

// ===== dv/sensor_spi_config_slave_test.sv
// self-checking bench for the serial configuration slave
`default_nettype none
`define CHK(got, exp) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		num_errors++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
	end \
end
module sensor_spi_config_slave_test
	import spi_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic          sys_clk;
	logic          nrst;
	logic          ce;
	logic          sck;
	logic          csn_n;
	logic          mosi;
	logic          miso;
	logic          miso_oe_n;
	logic          frame_start;
	logic          soft_reset;
	sensor_state_e sensor_state;
	logic [15:0]   line_length;
	logic [15:0]   streaming_state_req;
	logic [15:0]   rd;
	int            num_errors;
	int            comparisons;
	int            cycles;
	int            resets_seen;

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	sensor_spi_config_slave uut (
		.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .sck(sck), .csn_n(csn_n),
		.mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n), .sensor_state(sensor_state),
		.frame_start(frame_start), .line_length(line_length),
		.streaming_state_req(streaming_state_req), .soft_reset(soft_reset)
	);

	spi_host_model host (
		.sys_clk(sys_clk), .sck(sck), .csn_n(csn_n), .mosi(mosi), .miso(miso),
		.miso_oe_n(miso_oe_n)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic pulse_frame();
		@(negedge sys_clk);
		frame_start = 1'b1;
		@(negedge sys_clk);
		frame_start = 1'b0;
		repeat (3) @(negedge sys_clk);
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (soft_reset === 1'b1)
			resets_seen++;
		if (cycles == 30000) begin
			num_errors++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		frame_start = 1'b0;
		sensor_state = ST_CONFIG;
		repeat (10) @(negedge sys_clk);
		`CHK(line_length, RST_LINE_LENGTH)
		`CHK(streaming_state_req, RST_SENSOR_STATE)
		`CHK(miso_oe_n, 1'b1)
		nrst = 1'b1;
		repeat (3) @(negedge sys_clk);
		$display("test reset done");

		// restricted register written while streaming
		sensor_state = ST_STREAMING;
		host.xfer(16'h0201, 16'h1234, 32, rd);
		host.xfer(ADDR_LINE_LENGTH, 16'h0000, 32, rd);
		`CHK(rd, 16'h1234)
		pulse_frame();
		`CHK(line_length, RST_LINE_LENGTH)
		sensor_state = ST_CONFIG;
		repeat (3) @(negedge sys_clk);
		`CHK(line_length, 16'h1234)
		$display("test shadow done");

		// unrestricted register waits for the frame start
		sensor_state = ST_STREAMING;
		host.xfer(16'h4019, 16'h0003, 32, rd);
		host.xfer(ADDR_SENSOR_STATE, 16'h0000, 32, rd);
		`CHK(rd, 16'h0003)
		`CHK(streaming_state_req, RST_SENSOR_STATE)
		pulse_frame();
		`CHK(streaming_state_req, 16'h0003)
		$display("test frame apply done");

		// partial frame is lost, unmapped read gives zero
		sensor_state = ST_CONFIG;
		host.xfer(16'h0201, 16'h5555, 20, rd);
		host.xfer(ADDR_LINE_LENGTH, 16'h0000, 32, rd);
		`CHK(rd, 16'h1234)
		host.xfer(16'h0100, 16'h0000, 32, rd);
		`CHK(rd, 16'h0000)
		`CHK(miso_oe_n, 1'b1)
		$display("test abort done");

		// standby accepts only state and soft reset writes
		sensor_state = ST_STANDBY;
		host.xfer(16'h0201, 16'habcd, 32, rd);
		host.xfer(ADDR_LINE_LENGTH, 16'h0000, 32, rd);
		`CHK(rd, 16'h1234)
		host.xfer(16'h4019, 16'h0001, 32, rd);
		repeat (3) @(negedge sys_clk);
		`CHK(streaming_state_req, 16'h0001)
		`CHK(resets_seen, 0)
		host.xfer(16'h4061, 16'h0001, 32, rd);
		repeat (3) @(negedge sys_clk);
		`CHK(resets_seen, 1)
		$display("test standby done");

		// idle entry applies a line length written while streaming
		sensor_state = ST_STREAMING;
		host.xfer(16'h0201, 16'h0abc, 32, rd);
		`CHK(line_length, 16'h1234)
		sensor_state = ST_IDLE;
		repeat (3) @(negedge sys_clk);
		`CHK(line_length, 16'h0abc)
		$display("test idle done");

		// clock enable low freezes the port, so this frame is never seen
		ce = 1'b0;
		host.xfer(16'h0201, 16'h0bad, 32, rd);
		ce = 1'b1;
		repeat (3) @(negedge sys_clk);
		host.xfer(ADDR_LINE_LENGTH, 16'h0000, 32, rd);
		`CHK(rd, 16'h0abc)
		$display("test enable done");

		// reset in mid-run brings both stores back to their defaults
		nrst = 1'b0;
		repeat (2) @(negedge sys_clk);
		`CHK(line_length, RST_LINE_LENGTH)
		`CHK(streaming_state_req, RST_SENSOR_STATE)
		`CHK(miso_oe_n, 1'b1)
		nrst = 1'b1;
		repeat (3) @(negedge sys_clk);
		host.xfer(ADDR_LINE_LENGTH, 16'h0000, 32, rd);
		`CHK(rd, RST_LINE_LENGTH)
		$display("test late reset done");
		finish_test();
	end
endmodule
`default_nettype wire
